/* rtl/spm_consts.vh */
// Functional notes
// - Channel 1 clock pin: high clock enable gives input, else async/low enable output.
// - Channel 0 clock pin uses the same selection with its own bits.
// - Interrupt inputs five and four stay usable while clock pins are general port.
// - Channel 1 receive pin is serial input when receive enable is set.
// - Channel 0 receive pin is serial input on smart-card select or receive enable.
// - Channel 0 transmit pin is serial output on smart-card select or transmit enable.
// - Smart-card transmit pin alternates between driven and high impedance.
// - Port A pin is output when its direction bit is one, else input.
// - Modes 3 and 6 hold port A bit 7 direction at one, driving address.
// - Port A direction register is write-only and reads as all ones.
// - Reset or hardware standby loads direction 0x00, or 0x80 in modes 3, 6.
// - Software standby keeps registers and keeps output pins driven.
// - Port A read gives latch for output bits, pin level for input bits.
// - Port A data register resets to 0x00 on reset and hardware standby.
// - Next-data enabled bits ignore writes and load only from next-data transfers.
// - Unclaimed serial port pins follow their direction bit.
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define SPM_ADDR_W 16
`define SPM_OFS_SER_DIR 16'hffd0
`define SPM_OFS_PA_DIR 16'hffd1
`define SPM_OFS_SER_DATA 16'hffd2
`define SPM_OFS_PA_DATA 16'hffd3

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define SPM_PA_DIR_RST 8'h00
`define SPM_PA_DIR_RST_ADDR 8'h80
`define SPM_PA_DATA_RST 8'h00
`define SPM_SER_DIR_RST 8'hc0
`define SPM_SER_DATA_RST 8'hc0
`define SPM_SER_FIXED_MASK 8'hc0
`define SPM_ALL_ONES 8'hff
`define SPM_UNMAPPED 8'h00
`define SPM_PA_ADDR_BIT 7
`define SPM_MODE_ADDR_A 3'h3
`define SPM_MODE_ADDR_B 3'h6
`define SPM_SYNC_W 14

// Serial port pin positions.
`define SPM_P_SERIAL_CLK_CH1 5
`define SPM_P_SERIAL_CLK_CH0 4
`define SPM_P_RX1 3
`define SPM_P_RX0 2
`define SPM_P_TX0 0

`endif

/* rtl/spm_pin_mux.v */
`include "spm_consts.vh"

module spm_pin_mux (
  core_clk,
  reset_n,
  clk_en,
  op_mode,
  hw_standby_n,
  sw_standby,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  pa_in,
  pa_out,
  pa_oe,
  addr_high_bit,
  next_data_enable_reg,
  next_data_reg,
  next_data_load,
  ser_in,
  ser_out,
  ser_oe,
  ch1_clk_enable_high,
  ch1_clk_enable_low,
  ch1_async_sel,
  ch1_receive_enable,
  ch1_clk_out,
  ch0_clk_enable_high,
  ch0_clk_enable_low,
  ch0_async_sel,
  ch0_receive_enable,
  ch0_transmit_enable,
  smart_card_select,
  ch0_clk_out,
  ch0_tx_data,
  ch0_tx_drive,
  serial_clk_ch1,
  serial_clk_ch0,
  rx_pin_ch1,
  rx_pin_ch0,
  ext_irq_five,
  ext_irq_four
);
  input wire core_clk;
  input wire reset_n;
  input wire clk_en;
  input wire [2:0] op_mode;
  input wire hw_standby_n;
  input wire sw_standby;
  input wire [15:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  input wire [7:0] pa_in;
  output reg [7:0] pa_out;
  output reg [7:0] pa_oe;
  input wire addr_high_bit;
  input wire [7:0] next_data_enable_reg;
  input wire [7:0] next_data_reg;
  input wire [1:0] next_data_load;
  input wire [5:0] ser_in;
  output reg [5:0] ser_out;
  output reg [5:0] ser_oe;
  input wire ch1_clk_enable_high;
  input wire ch1_clk_enable_low;
  input wire ch1_async_sel;
  input wire ch1_receive_enable;
  input wire ch1_clk_out;
  input wire ch0_clk_enable_high;
  input wire ch0_clk_enable_low;
  input wire ch0_async_sel;
  input wire ch0_receive_enable;
  input wire ch0_transmit_enable;
  input wire smart_card_select;
  input wire ch0_clk_out;
  input wire ch0_tx_data;
  input wire ch0_tx_drive;
  output wire serial_clk_ch1;
  output wire serial_clk_ch0;
  output wire rx_pin_ch1;
  output wire rx_pin_ch0;
  output wire ext_irq_five;
  output wire ext_irq_four;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  function addr_mode;
    input [2:0] mode;
    begin
      addr_mode = (mode == `SPM_MODE_ADDR_A) || (mode == `SPM_MODE_ADDR_B);
    end
  endfunction

  function [7:0] dir_init;
    input [2:0] mode;
    begin
      if (addr_mode(mode)) begin
        dir_init = `SPM_PA_DIR_RST_ADDR;
      end else begin
        dir_init = `SPM_PA_DIR_RST;
      end
    end
  endfunction

  reg [7:0] pa_dir_r;
  reg [7:0] pa_dir_nxt;
  reg [7:0] pa_data_r;
  reg [7:0] pa_data_nxt;
  reg [7:0] ser_dir_r;
  reg [7:0] ser_dir_nxt;
  reg [7:0] ser_data_r;
  reg [7:0] ser_data_nxt;
  reg init_pend_r;
  reg [7:0] rdata_nxt;
  reg [7:0] pa_out_nxt;
  reg [7:0] pa_oe_nxt;
  reg [5:0] ser_out_nxt;
  reg [5:0] ser_oe_nxt;
  wire [13:0] pins_sync;
  wire [7:0] pa_sync;
  wire [5:0] ser_sync;
  wire amode;
  wire [7:0] pa_dir_eff;
  wire [7:0] nd_mask;
  wire reinit;
  integer i;

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  spm_sync2 #(
    .W(`SPM_SYNC_W)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in({ser_in, pa_in}),
    .sync_out(pins_sync)
  );

  assign pa_sync = pins_sync[7:0];
  assign ser_sync = pins_sync[13:8];
  assign amode = addr_mode(op_mode);
  assign reinit = init_pend_r || !hw_standby_n;

  // Bit 7 is forced to output in the address modes whatever is stored.
  assign pa_dir_eff = {pa_dir_r[7] | amode, pa_dir_r[6:0]};

  // Group 0 covers bits 3 to 0, group 1 covers bits 7 to 4.
  assign nd_mask = {{4{next_data_load[1]}}, {4{next_data_load[0]}}} & next_data_enable_reg;

  // The serial units and interrupt inputs see the synchronised pin levels.
  assign serial_clk_ch1 = ser_sync[`SPM_P_SERIAL_CLK_CH1];
  assign serial_clk_ch0 = ser_sync[`SPM_P_SERIAL_CLK_CH0];
  assign rx_pin_ch1 = ser_sync[`SPM_P_RX1];
  assign rx_pin_ch0 = ser_sync[`SPM_P_RX0];
  assign ext_irq_five = ser_sync[`SPM_P_SERIAL_CLK_CH1];
  assign ext_irq_four = ser_sync[`SPM_P_SERIAL_CLK_CH0];

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @* begin
    pa_dir_nxt = pa_dir_r;
    pa_data_nxt = pa_data_r;
    ser_dir_nxt = ser_dir_r;
    ser_data_nxt = ser_data_r;
    if (reinit) begin
      pa_dir_nxt = dir_init(op_mode);
      pa_data_nxt = `SPM_PA_DATA_RST;
      ser_dir_nxt = `SPM_SER_DIR_RST;
      ser_data_nxt = `SPM_SER_DATA_RST;
    end else begin
      // Software standby changes nothing here, so contents survive it.
      if (reg_wr && reg_addr == `SPM_OFS_PA_DIR) begin
        pa_dir_nxt = reg_wdata;
        if (amode) begin
          pa_dir_nxt[`SPM_PA_ADDR_BIT] = 1'b1;
        end
      end
      if (reg_wr && reg_addr == `SPM_OFS_PA_DATA) begin
        // Enabled bits keep their value against software writes.
        pa_data_nxt = (reg_wdata & ~next_data_enable_reg) |
                      (pa_data_r & next_data_enable_reg);
      end
      // A transfer in the same cycle as a write wins on its own bits.
      pa_data_nxt = (pa_data_nxt & ~nd_mask) | (next_data_reg & nd_mask);
      if (reg_wr && reg_addr == `SPM_OFS_SER_DIR) begin
        ser_dir_nxt = reg_wdata | `SPM_SER_FIXED_MASK;
      end
      if (reg_wr && reg_addr == `SPM_OFS_SER_DATA) begin
        ser_data_nxt = reg_wdata | `SPM_SER_FIXED_MASK;
      end
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always @* begin
    rdata_nxt = `SPM_UNMAPPED;
    case (reg_addr)
      `SPM_OFS_PA_DIR: begin
        rdata_nxt = `SPM_ALL_ONES;
      end
      `SPM_OFS_SER_DIR: begin
        rdata_nxt = `SPM_ALL_ONES;
      end
      `SPM_OFS_PA_DATA: begin
        rdata_nxt = (pa_data_r & pa_dir_eff) | (pa_sync & ~pa_dir_eff);
      end
      `SPM_OFS_SER_DATA: begin
        rdata_nxt = (ser_data_r & ser_dir_r) | ({2'b00, ser_sync} & ~ser_dir_r) |
                    `SPM_SER_FIXED_MASK;
      end
      default: begin
        rdata_nxt = `SPM_UNMAPPED;
      end
    endcase
  end

  // ****************************************************************
  // Pin function selection
  // ****************************************************************
  always @* begin
    // Output bits keep driving in software standby; the latch is unchanged.
    for (i = 0; i < 8; i = i + 1) begin
      pa_out_nxt[i] = pa_data_r[i];
      pa_oe_nxt[i] = pa_dir_eff[i];
    end
    if (amode) begin
      pa_out_nxt[`SPM_PA_ADDR_BIT] = addr_high_bit;
    end
    for (i = 0; i < 6; i = i + 1) begin
      ser_out_nxt[i] = ser_data_r[i];
      ser_oe_nxt[i] = ser_dir_r[i];
    end
    if (ch1_clk_enable_high) begin
      ser_oe_nxt[`SPM_P_SERIAL_CLK_CH1] = 1'b0;
    end else if (ch1_async_sel || ch1_clk_enable_low) begin
      ser_out_nxt[`SPM_P_SERIAL_CLK_CH1] = ch1_clk_out;
      ser_oe_nxt[`SPM_P_SERIAL_CLK_CH1] = 1'b1;
    end
    if (ch0_clk_enable_high) begin
      ser_oe_nxt[`SPM_P_SERIAL_CLK_CH0] = 1'b0;
    end else if (ch0_async_sel || ch0_clk_enable_low) begin
      ser_out_nxt[`SPM_P_SERIAL_CLK_CH0] = ch0_clk_out;
      ser_oe_nxt[`SPM_P_SERIAL_CLK_CH0] = 1'b1;
    end
    if (ch1_receive_enable) begin
      ser_oe_nxt[`SPM_P_RX1] = 1'b0;
    end
    if (smart_card_select || ch0_receive_enable) begin
      ser_oe_nxt[`SPM_P_RX0] = 1'b0;
    end
    if (smart_card_select) begin
      ser_out_nxt[`SPM_P_TX0] = ch0_tx_data;
      ser_oe_nxt[`SPM_P_TX0] = ch0_tx_drive;
    end else if (ch0_transmit_enable) begin
      ser_out_nxt[`SPM_P_TX0] = ch0_tx_data;
      ser_oe_nxt[`SPM_P_TX0] = 1'b1;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  // The mode strap is caught one enabled cycle after reset release, since
  // an asynchronous reset may only load constants.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_pend_r <= 1'b1;
      pa_dir_r <= `SPM_PA_DIR_RST;
      pa_data_r <= `SPM_PA_DATA_RST;
      ser_dir_r <= `SPM_SER_DIR_RST;
      ser_data_r <= `SPM_SER_DATA_RST;
      reg_rdata <= `SPM_UNMAPPED;
      pa_out <= 8'h00;
      pa_oe <= 8'h00;
      ser_out <= 6'h00;
      ser_oe <= 6'h00;
    end else if (clk_en) begin
      init_pend_r <= 1'b0;
      pa_dir_r <= pa_dir_nxt;
      pa_data_r <= pa_data_nxt;
      ser_dir_r <= ser_dir_nxt;
      ser_data_r <= ser_data_nxt;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end else begin
        reg_rdata <= `SPM_UNMAPPED;
      end
      pa_out <= pa_out_nxt;
      pa_oe <= pa_oe_nxt;
      ser_out <= ser_out_nxt;
      ser_oe <= ser_oe_nxt;
    end
  end
endmodule

/* rtl/spm_sync2.v */
module spm_sync2 #(
  parameter W = 14
) (
  core_clk,
  reset_n,
  clk_en,
  async_in,
  sync_out
);
  input wire core_clk;
  input wire reset_n;
  input wire clk_en;
  input wire [W-1:0] async_in;
  output reg [W-1:0] sync_out;

  reg [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* verif/spm_pin_model.sv */
module spm_pin_model (
  input logic [7:0] pa_out,
  input logic [7:0] pa_oe,
  input logic [7:0] pa_ext,
  input logic [5:0] ser_out,
  input logic [5:0] ser_oe,
  input logic [5:0] ser_ext,
  output logic [7:0] pa_in,
  output logic [5:0] ser_in
);
  // ****
  // Pin levels
  // ****
  // A pin the block does not drive carries the level of the outside device.
  assign pa_in = (pa_out & pa_oe) | (pa_ext & ~pa_oe);
  assign ser_in = (ser_out & ser_oe) | (ser_ext & ~ser_oe);
endmodule

/* verif/spm_pin_mux_checker.sv */
module spm_pin_mux_checker (
  input logic core_clk,
  input logic reset_n,
  input logic [2:0] op_mode,
  input logic [15:0] reg_addr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic [7:0] pa_out,
  input logic [7:0] pa_oe,
  input logic addr_high_bit,
  input logic [5:0] ser_in,
  input logic [5:0] ser_out,
  input logic [5:0] ser_oe,
  input logic ch1_clk_enable_high,
  input logic ch1_clk_enable_low,
  input logic ch1_async_sel,
  input logic ch1_receive_enable,
  input logic ch1_clk_out,
  input logic ch0_receive_enable,
  input logic ch0_transmit_enable,
  input logic smart_card_select,
  input logic ch0_tx_data,
  input logic ch0_tx_drive,
  input logic ext_irq_five
);
  // ****
  // Pin selection and read path
  // ****
  // Pin checks wait three edges after reset so the loaded strap and flops settle; the read-data checks do not.
  logic [1:0] up_r;
  logic live;
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  assign live = (up_r == 2'h3);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_dir_rd; reg_rd && reg_addr == 16'hffd1; endsequence
  sequence s_addr_mode; live && (op_mode == 3'h3 || op_mode == 3'h6); endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_dir_reads_ones: assert property (s_dir_rd |=> reg_rdata == 8'hff)
    else $error("direction read not ones");
  a_addr_bit_out: assert property (s_addr_mode |=> pa_oe[7] && pa_out[7] == $past(addr_high_bit))
    else $error("address bit not driven");
  a_ch1_clk_in: assert property (live && ch1_clk_enable_high |=> !ser_oe[5])
    else $error("clock pin not input");
  a_ch1_clk_out: assert property (live && !ch1_clk_enable_high &&
    (ch1_async_sel || ch1_clk_enable_low) |=> ser_oe[5] && ser_out[5] == $past(ch1_clk_out))
    else $error("clock pin not output");
  a_rx1_claim: assert property (live && ch1_receive_enable |=> !ser_oe[3])
    else $error("rx1 pin driven");
  a_rx0_claim: assert property (live && (smart_card_select || ch0_receive_enable) |=> !ser_oe[2])
    else $error("rx0 pin driven");
  a_tx0_drive: assert property (live && !smart_card_select && ch0_transmit_enable
    |=> ser_oe[0] && ser_out[0] == $past(ch0_tx_data))
    else $error("tx0 not driven");
  a_tx0_tristate: assert property (live && smart_card_select |=> ser_oe[0] == $past(ch0_tx_drive))
    else $error("tx0 enable wrong");
  a_irq_sync_path: assert property (live |-> ext_irq_five == $past(ser_in[5], 2))
    else $error("irq level not synchronised");
endmodule

bind spm_pin_mux spm_pin_mux_checker i_spm_pin_mux_checker (.*);

/* verif/spm_pin_mux_tb.sv */
module spm_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Stimulus and checks
  // ****
  logic core_clk = 0, reset_n = 0, clk_en = 1, hw_standby_n = 1, sw_standby = 0;
  logic reg_wr = 0, reg_rd = 0, addr_high_bit = 0;
  logic [2:0] op_mode = 3'h1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, pa_in, pa_out, pa_oe, pa_ext = 8'h5a;
  logic [7:0] next_data_enable_reg = 8'h00, next_data_reg = 8'h00, d, dv, dd, e;
  logic [1:0] next_data_load = 2'h0;
  logic [5:0] ser_in, ser_out, ser_oe, ser_ext = 6'h15, sd, sv, eo, eoe, p;
  logic [13:0] ctl = 14'h0000;
  logic serial_clk_ch1, serial_clk_ch0, rx_pin_ch1, rx_pin_ch0, ext_irq_five, ext_irq_four;
  logic [2:0] modes [5] = '{3'h3, 3'h6, 3'h1, 3'h5, 3'h7};
  logic [31:0] seed;
  int err_count = 0, total_checks = 0;
  spm_pin_mux i_spm_pin_mux (
    .*,
    .ch1_clk_enable_high(ctl[0]),
    .ch1_clk_enable_low(ctl[1]),
    .ch1_async_sel(ctl[2]),
    .ch1_receive_enable(ctl[3]),
    .ch1_clk_out(ctl[4]),
    .ch0_clk_enable_high(ctl[5]),
    .ch0_clk_enable_low(ctl[6]),
    .ch0_async_sel(ctl[7]),
    .ch0_receive_enable(ctl[8]),
    .ch0_transmit_enable(ctl[9]),
    .smart_card_select(ctl[10]),
    .ch0_clk_out(ctl[11]),
    .ch0_tx_data(ctl[12]),
    .ch0_tx_drive(ctl[13])
  );
  spm_pin_model i_spm_pin_model (.*);
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) addr_high_bit <= ~addr_high_bit;
  function automatic logic [5:0] exp_oe(logic [13:0] c, logic [5:0] r);
    exp_oe[5] = c[0] ? 1'b0 : (c[2] | c[1]) ? 1'b1 : r[5];
    exp_oe[4] = c[5] ? 1'b0 : (c[7] | c[6]) ? 1'b1 : r[4];
    exp_oe[3] = c[3] ? 1'b0 : r[3];
    exp_oe[2] = (c[10] | c[8]) ? 1'b0 : r[2];
    exp_oe[1] = r[1];
    exp_oe[0] = c[10] ? c[13] : c[9] ? 1'b1 : r[0];
  endfunction
  function automatic logic [5:0] exp_out(logic [13:0] c, logic [5:0] r);
    exp_out = r;
    if (!c[0] && (c[2] | c[1])) exp_out[5] = c[4];
    if (!c[5] && (c[7] | c[6])) exp_out[4] = c[11];
    if (c[10] | c[9]) exp_out[0] = c[12];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    close_out;
  end
  initial begin
    seed = $urandom(5);
    foreach (modes[i]) begin
      reset_n <= 1'b0;
      op_mode <= modes[i];
      cyc(3);
      reset_n <= 1'b1;
      cyc(3);
      e = (modes[i] == 3'h3 || modes[i] == 3'h6) ? 8'h80 : 8'h00;
      chk(pa_oe, e);
      wr(16'hffd1, 8'h00);
      cyc(4);
      chk(pa_oe, e);
      rd(16'hffd3, d);
      chk(d, pa_ext & ~e);
    end
    repeat (40) begin
      dv = 8'($urandom);
      dd = 8'($urandom);
      sd = 6'($urandom);
      sv = 6'($urandom);
      pa_ext <= 8'($urandom);
      ser_ext <= 6'($urandom);
      ctl <= 14'($urandom);
      wr(16'hffd1, dv);
      wr(16'hffd3, dd);
      wr(16'hffd0, {2'h0, sd});
      wr(16'hffd2, {2'h0, sv});
      cyc(4);
      eoe = exp_oe(ctl, sd);
      eo = exp_out(ctl, sv);
      p = (eo & eoe) | (ser_ext & ~eoe);
      chk({2'h0, ser_out & eoe}, {2'h0, eo & eoe});
      chk({2'h0, serial_clk_ch1, serial_clk_ch0, rx_pin_ch1, rx_pin_ch0, ext_irq_five,
           ext_irq_four}, {2'h0, p[5], p[4], p[3], p[2], p[5], p[4]});
      rd(16'hffd2, d);
      chk(d, ({2'h0, sv} & {2'h0, sd}) | ({2'h0, p} & ~{2'h0, sd}) | 8'hc0);
      rd(16'hffd0, d);
      chk(d, 8'hff);
      chk(pa_oe, dv);
      chk(pa_out, dd);
      chk({2'h0, ser_oe}, {2'h0, exp_oe(ctl, sd)});
      rd(16'hffd1, d);
      chk(d, 8'hff);
      rd(16'hffd3, d);
      chk(d, (dd & dv) | (pa_ext & ~dv));
      rd(16'hffd4, d);
      chk(d, 8'h00);
    end
    sw_standby <= 1'b1;
    cyc(5);
    chk(pa_oe, dv);
    chk(pa_out, dd);
    sw_standby <= 1'b0;
    wr(16'hffd1, 8'hff);
    wr(16'hffd3, 8'h00);
    next_data_enable_reg <= 8'h0f;
    next_data_reg <= 8'h3c;
    wr(16'hffd3, 8'hff);
    cyc(2);
    chk(pa_out, 8'hf0);
    @(posedge core_clk);
    next_data_load <= 2'h3;
    @(posedge core_clk);
    next_data_load <= 2'h0;
    cyc(2);
    chk(pa_out, 8'hfc);
    hw_standby_n <= 1'b0;
    cyc(2);
    hw_standby_n <= 1'b1;
    cyc(3);
    chk(pa_oe, 8'h00);
    chk(pa_out, 8'h00);
    close_out;
  end
endmodule
